//--- rtl/can_xcvr_ctrl.sv
// mode, wake-up and fault control of a high-speed can transceiver
//
// Contract
// RULE_01 - standby input low selects normal mode, high selects standby mode.
// RULE_02 - normal mode carries transmit bits to bus and bus state to rxd.
// RULE_03 - transmit input low drives dominant, high leaves bus recessive.
// RULE_04 - in normal mode rxd is low on dominant, high on recessive.
// RULE_05 - standby disables transmitter and receiver; low-power receiver watches bus.
// RULE_06 - wake needs dominant, recessive, dominant, each at least filter time.
// RULE_07 - wake detection resets if the pattern misses the wake window.
// RULE_08 - standby rxd high until wake recognised, then follows the bus.
// RULE_09 - overtemperature indication switches the transmitter off.
// RULE_10 - during thermal shutdown reception and mode control keep working.
// RULE_11 - thermal off ends only when temperature cleared and transmit high.
// RULE_12 - transmit low beyond dominant timeout disables transmitter.
// RULE_13 - transmit rising edge resets timeout timer and clears disable.
// RULE_14 - controller keeps bit rate at or above 17 kbps.
// RULE_15 - main supply standby undervoltage forces standby mode.
// RULE_16 - io supply undervoltage also forces standby mode.
// RULE_17 - switch-off undervoltage disengages from bus until supply recovers.
// RULE_18 - after supply recovery, no dominant until transmit input went high.
// RULE_19 - undervoltage recovery takes the mode change delay.
// RULE_20 - unconnected transmit or standby input reads high.
// RULE_21 - wake detection stays alive from io supply without main supply.
// RULE_22 - standby ignores transmit input and never drives dominant.
`include "can_xcvr_params.svh"
`timescale 1ns/1ps
`default_nettype none

module can_xcvr_ctrl #(
  parameter int CLK_NS     = `CLK_PERIOD_NS,
  parameter int WAKE_FILT  = (`WAKE_FILT_NS + `CLK_PERIOD_NS - 1)
                             / `CLK_PERIOD_NS,
  parameter int WAKE_WIN   = `WAKE_WINDOW_NS / `CLK_PERIOD_NS,
  parameter int DOM_TMO    = `DOM_TIMEOUT_NS / `CLK_PERIOD_NS,
  parameter int MODE_DLY   = (`MODE_CHANGE_NS + `CLK_PERIOD_NS - 1)
                             / `CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // controller pins, already resolved for pull-ups by the pad
  input  wire logic        txd,
  input  wire logic        stb,
  output logic             rxd,
  // bus side: receiver level and driver request
  input  wire logic        bus_dominant,
  output logic             drive_dominant,
  output logic             standby_mode,
  // analog monitor indications
  input  wire logic        overtemp,
  input  wire logic        vcc_stby_uv,
  input  wire logic        io_uv,
  input  wire logic        off_uv,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  can_xcvr_pkg::state_t s;
  can_xcvr_pkg::state_t next_s;

  // saturating-free compare helper used by all timers
  function automatic logic reached(input logic [23:0] cnt, input int lim);
    reached = (cnt >= 24'(lim));
  endfunction

  // two-flop synchroniser step shared by every pin input except txd, which has its own three-stage shift
  function automatic logic [1:0] sync2(input logic [1:0] q,
                                       input logic       d);
    sync2 = {q[0], d};
  endfunction

  // a clear drops only what was held; an event raised now survives it
  function automatic logic [3:0] merge_events(input logic [3:0] held,
                                              input logic [3:0] raised,
                                              input logic [3:0] clr);
    merge_events = (held & ~clr) | raised;
  endfunction

  // status word: live flags above the sticky events
  function automatic logic [31:0] status_word(
    input can_xcvr_pkg::state_t st
  );
    status_word = {20'h00000, 4'(st.wk), st.standby, st.thermal_off,
                   st.dom_trip, st.uv_lock, st.events};
  endfunction

  logic txd_q, txd_p, bus_q, want_stby, txd_rise, txd_fall;
  logic aw_go, w_go;
  logic [3:0] ev_set;

  always_comb begin
    next_s = s;
    ev_set = 4'h0;
    // pins pass two flops; third stage only for edge detection
    next_s.txd_s   = {s.txd_s[1:0], txd};
    next_s.stb_s   = sync2(s.stb_s, stb);
    next_s.bus_s   = sync2(s.bus_s, bus_dominant);
    next_s.ot_s    = sync2(s.ot_s, overtemp);
    next_s.uv_s    = sync2(s.uv_s, vcc_stby_uv);
    next_s.io_uv_s = sync2(s.io_uv_s, io_uv);
    next_s.off_s   = sync2(s.off_s, off_uv);
    txd_q    = s.txd_s[1];
    txd_p    = s.txd_s[2];
    bus_q    = s.bus_s[1];
    txd_rise = txd_q & ~txd_p;
    txd_fall = ~txd_q & txd_p;

    // mode request; undervoltage of either supply forces standby
    want_stby = s.stb_s[1] | s.uv_s[1] | s.io_uv_s[1] | s.off_s[1]
              | s.sw_force_stby; // [RULE_01] [RULE_15] [RULE_16] [RULE_20]
    if (want_stby) begin
      next_s.standby   = 1'b1;
      next_s.mode_pend = 1'b0;
      next_s.mode_cnt  = '0;
    end else if (s.standby) begin
      // leaving standby costs the mode change delay [RULE_19]
      next_s.mode_pend = 1'b1;
      next_s.mode_cnt  = s.mode_cnt + 16'h0001;
      if (reached({8'h00, s.mode_cnt}, MODE_DLY - 1)) begin
        next_s.standby   = 1'b0;
        next_s.mode_pend = 1'b0;
        next_s.mode_cnt  = '0;
      end
    end

    // supply loss locks the driver until txd is seen high [RULE_17] [RULE_18]
    // a level release, so a txd stuck high at recovery frees at once
    if (s.off_s[1] | s.uv_s[1] | s.io_uv_s[1]) begin
      next_s.uv_lock = 1'b1;
    end else if (txd_q) begin
      next_s.uv_lock = 1'b0;
    end

    // thermal off, released only by cool and txd high [RULE_09] [RULE_11]
    if (s.ot_s[1]) begin
      next_s.thermal_off = 1'b1;
    end else if (txd_q) begin
      next_s.thermal_off = 1'b0;
    end

    // dominant timeout [RULE_12] [RULE_13]
    if (txd_rise | txd_q) begin
      next_s.dom_cnt  = '0;
      next_s.dom_trip = 1'b0;
    end else if (txd_fall) begin
      next_s.dom_cnt = 24'h000001;
    end else if (!s.dom_trip) begin
      next_s.dom_cnt = s.dom_cnt + 24'h000001;
      // trip stops the count so the timer read shows the limit reached
      if (reached(s.dom_cnt, DOM_TMO)) begin
        next_s.dom_trip = 1'b1;
      end
    end

    // driver; standby ignores txd entirely [RULE_03] [RULE_05] [RULE_22]
    next_s.drive_dom = ~txd_q & ~next_s.standby & ~next_s.thermal_off
                     & ~next_s.dom_trip & ~next_s.uv_lock
                     & ~s.off_s[1]; // [RULE_02] [RULE_10]

    // wake detector, started only from standby [RULE_06] [RULE_21]
    next_s.filt_cnt = s.filt_cnt + 16'h0001;
    next_s.win_cnt  = s.win_cnt + 24'h000001;
    unique case (s.wk)
      can_xcvr_pkg::wk_idle: begin
        next_s.win_cnt  = '0;
        next_s.filt_cnt = '0;
        if (s.standby & bus_q)
          next_s.wk = can_xcvr_pkg::wk_dom1;
      end
      can_xcvr_pkg::wk_dom1: begin
        if (!bus_q) begin
          next_s.filt_cnt = '0;
          if (reached({8'h00, s.filt_cnt}, WAKE_FILT - 1))
            next_s.wk = can_xcvr_pkg::wk_rec;
          else
            next_s.wk = can_xcvr_pkg::wk_idle;
        end
      end
      can_xcvr_pkg::wk_rec: begin
        if (bus_q) begin
          next_s.filt_cnt = '0;
          if (!reached({8'h00, s.filt_cnt}, WAKE_FILT - 1))
            next_s.filt_cnt = '0;
          else
            next_s.wk = can_xcvr_pkg::wk_dom2;
        end
      end
      can_xcvr_pkg::wk_dom2: begin
        if (!bus_q) begin
          next_s.filt_cnt = '0;
          next_s.wk = can_xcvr_pkg::wk_rec;
        end else if (reached({8'h00, s.filt_cnt}, WAKE_FILT - 1)) begin
          next_s.wk = can_xcvr_pkg::wk_done;
          ev_set[0] = 1'b1;
        end
      end
      can_xcvr_pkg::wk_done: begin
        next_s.win_cnt  = '0;
        next_s.filt_cnt = '0;
        if (!s.standby)
          next_s.wk = can_xcvr_pkg::wk_idle;
      end
    endcase
    // window expiry resets the pattern [RULE_07]
    if (s.wk != can_xcvr_pkg::wk_idle && s.wk != can_xcvr_pkg::wk_done
        && reached(s.win_cnt, WAKE_WIN)) begin
      next_s.wk = can_xcvr_pkg::wk_idle;
    end

    // receiver output [RULE_04] [RULE_08]
    if (!s.standby) begin
      next_s.rxd = ~bus_q;
    end else if (s.wk == can_xcvr_pkg::wk_done) begin
      next_s.rxd = ~bus_q;
    end else begin
      next_s.rxd = 1'b1;
    end

    // sticky events; hardware set wins over software clear
    if (next_s.dom_trip & ~s.dom_trip) begin
      ev_set[1] = 1'b1;
    end
    if (next_s.thermal_off & ~s.thermal_off) begin
      ev_set[2] = 1'b1;
    end
    if (next_s.uv_lock & ~s.uv_lock) begin
      ev_set[3] = 1'b1;
    end
    next_s.events = s.events | ev_set;

    // axi4-lite write: address and data taken in either order
    aw_go = s_axi_awvalid & ~s.awt & ~s.bvalid;
    w_go  = s_axi_wvalid & ~s.wt & ~s.bvalid;
    if (aw_go) begin
      next_s.awt   = 1'b1;
      next_s.waddr = s_axi_awaddr;
    end
    if (w_go) begin
      next_s.wt = 1'b1;
    end
    if (s.awt & s.wt) begin
      next_s.awt    = 1'b0;
      next_s.wt     = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = `AXI_OKAY;
      unique case (s.waddr)
        `REG_CTRL: begin
          if (s.rdata[31]) begin
            next_s.sw_force_stby = s.rdata[0];
          end
        end
        `REG_STATUS: begin
          if (s.rdata[31]) begin
            next_s.events = merge_events(s.events, ev_set, s.rdata[3:0]);
          end
        end
        `REG_TIMER:  ;
        default:     next_s.bresp = `AXI_SLVERR;
      endcase
    end
    if (s.bvalid & s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end

    // read path; rdata doubles as the write-data holding register
    if (w_go) begin
      next_s.rdata = {s_axi_wstrb[0], 27'h0000000, s_axi_wdata[3:0]};
    end else if (s_axi_arvalid & ~s.rvalid & ~s.wt) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = `AXI_OKAY;
      unique case (s_axi_araddr)
        `REG_CTRL:   next_s.rdata = {31'h00000000, s.sw_force_stby};
        `REG_STATUS: next_s.rdata = status_word(s);
        `REG_TIMER:  next_s.rdata = {8'h00, s.dom_cnt};
        default: begin
          next_s.rdata = 32'h00000000;
          next_s.rresp = `AXI_SLVERR;
        end
      endcase
    end
    if (s.rvalid & s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end

    // ready flags kept in flops so every port leaves a register;
    // they mirror the next state, so acceptance timing is unchanged
    next_s.axi_awready = ~next_s.awt & ~next_s.bvalid;
    next_s.axi_wready  = ~next_s.wt & ~next_s.bvalid;
    next_s.axi_arready = ~next_s.rvalid & ~next_s.wt;
    // read data masked while idle: rdata also holds pending write data
    if (next_s.rvalid) begin
      next_s.rdata_out = next_s.rdata;
    end else begin
      next_s.rdata_out = 32'h00000000;
    end

    // standby is the safe state out of reset
    if (!aresetn) begin
      next_s = '0;
      next_s.txd_s   = 3'h7;
      next_s.stb_s   = 2'h3;
      next_s.standby = 1'b1;
      next_s.rxd     = 1'b1;
      next_s.wk      = can_xcvr_pkg::wk_idle;
      next_s.axi_awready = 1'b1;
      next_s.axi_wready  = 1'b1;
      next_s.axi_arready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    s <= next_s;
  end

  // all outputs straight from state flops
  assign rxd            = s.rxd;
  assign drive_dominant = s.drive_dom;
  assign standby_mode   = s.standby;
  assign s_axi_awready  = s.axi_awready;
  assign s_axi_wready   = s.axi_wready;
  assign s_axi_bvalid   = s.bvalid;
  assign s_axi_bresp    = s.bresp;
  assign s_axi_arready  = s.axi_arready;
  assign s_axi_rvalid   = s.rvalid;
  assign s_axi_rdata    = s.rdata_out;
  assign s_axi_rresp    = s.rresp;

endmodule // can_xcvr_ctrl

`default_nettype wire

//--- rtl/can_xcvr_params.svh
// constants for the transceiver mode and fault control block
`ifndef CAN_XCVR_PARAMS_SVH
`define CAN_XCVR_PARAMS_SVH
`define CLK_PERIOD_NS      100
`define WAKE_FILT_NS       500
`define WAKE_WINDOW_NS     1000000
`define DOM_TIMEOUT_NS     1000000
`define MODE_CHANGE_NS     10000
`define REG_CTRL           8'h00
`define REG_STATUS         8'h04
`define REG_TIMER          8'h08
`define AXI_OKAY           2'h0
`define AXI_SLVERR         2'h2
`endif

//--- rtl/can_xcvr_pkg.sv
// types for the transceiver mode and fault control block
package can_xcvr_pkg;
  typedef enum logic [2:0] {
    wk_idle, wk_dom1, wk_rec, wk_dom2, wk_done
  } wake_state_t;

  typedef struct packed {
    logic standby_n;
    logic io_uv;
    logic vcc_stby_uv;
    logic vcc_off_uv;
    logic io_off_uv;
    logic overtemp;
  } supply_flags_t;

  typedef struct packed {
    logic [2:0]   txd_s;
    logic [1:0]   stb_s;
    logic [1:0]   bus_s;
    logic [1:0]   ot_s;
    logic [1:0]   uv_s;
    logic [1:0]   io_uv_s;
    logic [1:0]   off_s;
    logic         standby;
    logic         mode_pend;
    logic [15:0]  mode_cnt;
    wake_state_t  wk;
    logic [15:0]  filt_cnt;
    logic [23:0]  win_cnt;
    logic [23:0]  dom_cnt;
    logic         dom_trip;
    logic         thermal_off;
    logic         uv_lock;
    logic         drive_dom;
    logic         rxd;
    logic         sw_force_stby;
    logic         awt;
    logic         wt;
    logic [7:0]   waddr;
    logic         bvalid;
    logic [1:0]   bresp;
    logic         rvalid;
    logic [31:0]  rdata;
    logic [1:0]   rresp;
    logic [3:0]   events;
    logic         axi_awready;
    logic         axi_wready;
    logic         axi_arready;
    logic [31:0]  rdata_out;
  } state_t;
endpackage

//--- tb/can_ctrl_model.sv
// behavioural can controller driving transmit and standby pins
`timescale 1ns/1ps
`default_nettype none
module can_ctrl_model (
  // clock
  input  wire logic aclk,
  // pins toward the transceiver
  output var  logic txd,
  output var  logic stb
);
  // idle recessive and standby, like pins left to their pull-ups
  initial begin
    txd = 1'h1;
    stb = 1'h1;
  end
  // frames keep low runs short; only a stuck-bit test holds longer
  task automatic send(input logic v, input int n);
    @(posedge aclk);
    txd <= v;
    repeat (n) @(posedge aclk);
  endtask
  task automatic set_stb(input logic v);
    @(posedge aclk);
    stb <= v;
  endtask
endmodule // can_ctrl_model
`default_nettype wire

//--- tb/can_xcvr_chk_asserts.sv
// concurrent checks on the transceiver pins
`timescale 1ns/1ps
`default_nettype none
module can_xcvr_chk #(
  parameter int DOM_TMO = 50
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // controller and bus pins
  input wire logic txd,
  input wire logic stb,
  input wire logic rxd,
  input wire logic bus_dominant,
  input wire logic drive_dominant,
  input wire logic standby_mode,
  // monitors
  input wire logic overtemp,
  input wire logic vcc_stby_uv,
  input wire logic io_uv,
  input wire logic off_uv
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // a counter, since a repetition this long would crawl
  logic [15:0] run;
  always_ff @(posedge aclk) begin
    run <= (!aresetn || !drive_dominant) ? 16'h0000 : run + 16'h0001;
  end
  a_stby_quiet: assert property (
    standby_mode |-> !drive_dominant) else $error("drive in standby");
  a_dom_from_txd: assert property (
    drive_dominant |-> !$past(txd, 3)) else $error("drive without txd low");
  a_hot_tx_off: assert property (
    overtemp [*5] |-> !drive_dominant) else $error("drive while hot");
  a_uv_stby: assert property (
    vcc_stby_uv [*5] |-> standby_mode) else $error("no standby on uv");
  a_io_uv_stby: assert property (
    io_uv [*5] |-> standby_mode) else $error("no standby on io uv");
  a_off_uv_quiet: assert property (
    off_uv [*5] |-> !drive_dominant) else $error("drive at switch-off");
  a_rx_normal: assert property (
    (!standby_mode && !off_uv) [*5] |-> rxd == !$past(bus_dominant, 3))
    else $error("rxd not following bus");
  a_stb_selects: assert property (
    stb [*5] |-> standby_mode) else $error("stb high but not standby");
  a_mode_delay: assert property (
    $fell(standby_mode) |-> !$past(stb, 8) && !$past(vcc_stby_uv, 8))
    else $error("left standby too early");
  a_dom_limit: assert property (
    int'(run) <= DOM_TMO + 4) else $error("dominant run too long");
endmodule // can_xcvr_chk
bind can_xcvr_ctrl can_xcvr_chk #(.DOM_TMO(DOM_TMO)) i_chk (.aclk, .aresetn,
  .txd, .stb, .rxd, .bus_dominant, .drive_dominant, .standby_mode,
  .overtemp, .vcc_stby_uv, .io_uv, .off_uv);
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the transceiver control block
`include "can_xcvr_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int TMO = 50;
  localparam int WIN = 200;
  logic        aclk, aresetn, ext_dom, overtemp, vcc_stby_uv, io_uv, off_uv;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready;
  wire logic   txd, stb, rxd, drive_dominant, standby_mode, bus_dominant;
  wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire logic   s_axi_arready, s_axi_rvalid;
  wire logic [1:0]  s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  int          mismatches, comparisons;
  // wired-or bus: our driver or a remote node
  assign bus_dominant = drive_dominant | ext_dom;
  can_ctrl_model i_ctrl (.aclk, .txd, .stb);
  can_xcvr_ctrl #(.DOM_TMO(TMO), .WAKE_WIN(WIN), .WAKE_FILT(5),
    .MODE_DLY(10)) i_dut (.aclk, .aresetn, .txd, .stb, .rxd, .bus_dominant,
    .drive_dominant, .standby_mode, .overtemp, .vcc_stby_uv, .io_uv, .off_uv,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic axi_wr(logic [7:0] a, logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
  endtask
  task automatic axi_rd(logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  // remote node: dominant, recessive, dominant, then bus left as is
  task automatic wake(int d1, int r1, int d2);
    ext_dom <= 1'h1;
    cyc(d1);
    ext_dom <= 1'h0;
    cyc(r1);
    ext_dom <= 1'h1;
    cyc(d2);
  endtask
  task automatic t_normal;
    cyc(20);
    chk("stby", 1'h1, standby_mode);
    i_ctrl.set_stb(1'h0);
    cyc(20);
    chk("stby", 1'h0, standby_mode);
    i_ctrl.send(1'h0, 12);
    chk("drv", 1'h1, drive_dominant);
    chk("rxd", 1'h0, rxd);
    i_ctrl.send(1'h1, 12);
    chk("drv", 1'h0, drive_dominant);
    chk("rxd", 1'h1, rxd);
  endtask
  task automatic t_timeout;
    logic [31:0] d;
    logic [1:0]  r;
    i_ctrl.send(1'h0, TMO - 10);
    chk("drv", 1'h1, drive_dominant);
    i_ctrl.send(1'h0, 30);
    chk("drv", 1'h0, drive_dominant);
    axi_rd(`REG_STATUS, d, r);
    chk("status", 1'h1, d[1]);
    i_ctrl.send(1'h1, 5);
    i_ctrl.send(1'h0, 12);
    chk("drv", 1'h1, drive_dominant);
    i_ctrl.send(1'h1, 5);
  endtask
  task automatic t_thermal;
    i_ctrl.send(1'h0, 12);
    overtemp <= 1'h1;
    ext_dom <= 1'h1;
    cyc(8);
    chk("drv", 1'h0, drive_dominant);
    chk("rxd", 1'h0, rxd);
    chk("stby", 1'h0, standby_mode);
    ext_dom <= 1'h0;
    overtemp <= 1'h0;
    cyc(8);
    chk("rxd", 1'h1, rxd);
    chk("drv", 1'h0, drive_dominant);
    i_ctrl.send(1'h1, 5);
    i_ctrl.send(1'h0, 12);
    chk("drv", 1'h1, drive_dominant);
    i_ctrl.send(1'h1, 5);
  endtask
  task automatic t_supply;
    vcc_stby_uv <= 1'h1;
    i_ctrl.send(1'h0, 6);
    chk("stby", 1'h1, standby_mode);
    vcc_stby_uv <= 1'h0;
    cyc(5);
    chk("stby", 1'h1, standby_mode);
    cyc(15);
    chk("stby", 1'h0, standby_mode);
    chk("drv", 1'h0, drive_dominant);
    i_ctrl.send(1'h1, 5);
    i_ctrl.send(1'h0, 10);
    off_uv <= 1'h1;
    cyc(6);
    chk("drv", 1'h0, drive_dominant);
    off_uv <= 1'h0;
    cyc(20);
    chk("drv", 1'h0, drive_dominant);
    i_ctrl.send(1'h1, 5);
    io_uv <= 1'h1;
    cyc(6);
    chk("stby", 1'h1, standby_mode);
    io_uv <= 1'h0;
    cyc(20);
  endtask
  task automatic t_standby;
    i_ctrl.set_stb(1'h1);
    i_ctrl.send(1'h0, 10);
    chk("drv", 1'h0, drive_dominant);
    i_ctrl.send(1'h1, 2);
    wake(2, 10, 10);
    chk("rxd", 1'h1, rxd);
    ext_dom <= 1'h0;
    cyc(WIN + 50);
    wake(10, WIN, 10);
    chk("rxd", 1'h1, rxd);
    ext_dom <= 1'h0;
    cyc(WIN + 50);
    wake(10, 10, 15);
    chk("rxd", 1'h0, rxd);
    ext_dom <= 1'h0;
    cyc(8);
    chk("rxd", 1'h1, rxd);
    i_ctrl.set_stb(1'h0);
    cyc(20);
  endtask
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    axi_wr(`REG_CTRL, 32'h0000_0001);
    i_ctrl.send(1'h0, 8);
    chk("drv", 1'h0, drive_dominant);
    axi_rd(`REG_CTRL, d, r);
    chk("ctrl", 32'h0000_0001, d);
    axi_rd(8'h0C, d, r);
    chk("rresp", `AXI_SLVERR, r);
    axi_wr(`REG_CTRL, 32'h0000_0000);
    i_ctrl.send(1'h1, 20);
    chk("stby", 1'h0, standby_mode);
    axi_rd(`REG_STATUS, d, r);
    chk("wake_ev", 1'h1, d[0]);
    axi_wr(`REG_STATUS, 32'h0000_000F);
    axi_rd(`REG_STATUS, d, r);
    chk("events", 4'h0, d[3:0]);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    {aresetn, ext_dom, overtemp, vcc_stby_uv, io_uv, off_uv} = 6'h00;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    cyc(5);
    aresetn <= 1'h1;
    t_normal;
    t_timeout;
    t_thermal;
    t_supply;
    t_standby;
    t_regs;
    wrap_up;
  end
  // the whole run needs under two thousand clocks
  initial begin
    cyc(5000);
    mismatches++;
    wrap_up;
  end
endmodule // tb_top
`default_nettype wire
